// ===== odsm_ctrl_model.sv
`timescale 1ns/10ps
module odsm_ctrl_model (
    input wire logic core_clk,
    input wire logic [2:0] sel_req,
    input wire logic alarm_req,
    input wire logic hard_req,
    output logic data_select_bit0,
    output logic data_select_bit1,
    output logic data_select_bit2,
    output logic alarm_event,
    output logic [7:0] alarm_code,
    output logic alarm_no_reset
);
    // Code is only qualified by the event pulse, so it keeps changing in between
    always_ff @(posedge core_clk) begin
        {data_select_bit2, data_select_bit1, data_select_bit0} <= sel_req;
        alarm_event <= alarm_req;
        alarm_code <= alarm_req ? 8'h2A : ~alarm_code;
        alarm_no_reset <= hard_req;
    end
endmodule // odsm_ctrl_model

// ===== odsm_pkg.sv
// Summary of operation
// [RULE_01] Eight data sets in speed, torque, tension modes; four in position mode.
// [RULE_02] Stored operation data is held in the device, not in the panel.
// [RULE_03] Active data number is the binary value of select bits; two bits in position mode.
// [RULE_04] Edit lock refuses every change to operation data.
// [RULE_05] Out-of-range entry is rejected and an error shows for one second.
// [RULE_06] Position torque limit accepts 0 to 300 percent, resets to 0.
// [RULE_07] Damping frequency accepts 7.00 to 100.00 Hz, initial value 30.00 Hz.
// [RULE_08] Speed monitor in r/min, negative for CCW, or unsigned magnitude if selected.
// [RULE_09] Speed monitor optionally divided by deceleration ratio for gear output shaft.
// [RULE_10] Torque monitor reports percent, rated torque reads as 100.
// [RULE_11] Inertia monitor reports load to rotor inertia percent, 100 when equal.
// [RULE_12] Report data number in use, and select-input number in tension mode only.
// [RULE_13] Position mode only: command position relative to home, in steps.
// [RULE_14] Tension mode only: tension command, winding revolutions and roll diameter.
// [RULE_15] Alarm code with alarm reset and history clear; warning code with history clear.
// [RULE_16] Some alarms cannot be reset from the panel; only power cycle clears them.
// [RULE_17] Warning history is erased when driver power is removed.
// [RULE_18] Display blinks while alarm reset or history clear is in progress.
// [RULE_19] I/O monitor maps each signal to one digit, lit when on.
// [RULE_20] Analog speed and torque input voltages reported in 0.1 volt steps.
// [RULE_21] Monitored values kept within plus or minus 19,999,999.
// [RULE_22] Range check comes before commit; rejected entry leaves old value.
package odsm_pkg;
    typedef enum logic [1:0] {ODSM_POSITION, ODSM_SPEED, ODSM_TORQUE, ODSM_TENSION} odsm_mode_e;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DATA_WR = 8'h04;
    localparam logic [7:0] ADDR_DATA_IDX = 8'h08;
    localparam logic [7:0] ADDR_DATA_RD = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_SPEED = 8'h14;
    localparam logic [7:0] ADDR_TORQUE = 8'h18;
    localparam logic [7:0] ADDR_INERTIA = 8'h1C;
    localparam logic [7:0] ADDR_POSITION = 8'h20;
    localparam logic [7:0] ADDR_TENSION = 8'h24;
    localparam logic [7:0] ADDR_REVS = 8'h28;
    localparam logic [7:0] ADDR_ROLL = 8'h2C;
    localparam logic [7:0] ADDR_IO = 8'h30;
    localparam logic [7:0] ADDR_ANALOG = 8'h34;
    localparam logic [7:0] ADDR_GEAR = 8'h38;
    localparam logic [7:0] ADDR_ALARM = 8'h3C;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_LOCK_BIT = 2;
    localparam int CTRL_ABS_BIT = 3;
    localparam int CTRL_GEAR_BIT = 4;
    localparam int CTRL_ALM_RST_BIT = 8;
    localparam int CTRL_ALM_CLR_BIT = 9;
    localparam int CTRL_WRN_CLR_BIT = 10;
    localparam int DWR_IDX_LSB = 16;
    localparam int DWR_ITEM_BIT = 20;

    localparam int SETS_FULL = 8;
    localparam int SETS_POSITION = 4;
    localparam int TRQ_W = 9;
    localparam int DAMP_W = 14;
    localparam logic [15:0] TRQ_MAX = 16'h012C;
    localparam logic [15:0] DAMP_MIN = 16'h02BC;
    localparam logic [15:0] DAMP_MAX = 16'h2710;
    localparam logic [TRQ_W-1:0] TRQ_RESET = 9'h000;
    localparam logic [DAMP_W-1:0] DAMP_RESET = 14'h0BB8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] GEAR_RESET = 16'h0001;
    localparam logic signed [31:0] MON_LIMIT = 32'sh01312CFF;
    localparam logic signed [15:0] MV_PER_STEP = 16'sh0064;
    localparam logic [3:0] HIST_MAX = 4'hA;

    localparam int CLK_HZ = 10_000_000;
    localparam int ERR_TIME_MS = 1000;
    localparam int ERR_CYCLES = CLK_HZ / 1000 * ERR_TIME_MS;
    localparam int CLEAR_CYCLES = 4096;
    localparam int BLINK_BITS = 12;
endpackage

// ===== odsm_top.sv
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module odsm_top #(
    parameter int ERR_CYCLES = odsm_pkg::ERR_CYCLES,
    parameter int CLEAR_CYCLES = odsm_pkg::CLEAR_CYCLES,
    parameter int IO_W = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic data_select_bit0,
    input wire logic data_select_bit1,
    input wire logic data_select_bit2,
    input wire logic [IO_W-1:0] io_signals,
    input wire logic signed [31:0] speed_rpm,
    input wire logic signed [31:0] torque_pct,
    input wire logic signed [31:0] inertia_pct,
    input wire logic signed [31:0] cmd_position,
    input wire logic signed [31:0] tension_cmd,
    input wire logic signed [31:0] winding_revs,
    input wire logic signed [31:0] roll_diameter,
    input wire logic signed [15:0] analog_speed_mv,
    input wire logic signed [15:0] analog_torque_mv,
    input wire logic alarm_event,
    input wire logic [7:0] alarm_code,
    input wire logic alarm_no_reset,
    input wire logic warning_event,
    input wire logic [7:0] warning_code,
    output logic [2:0] op_number,
    output logic [odsm_pkg::TRQ_W-1:0] active_torque_limit,
    output logic [odsm_pkg::DAMP_W-1:0] active_damping,
    output logic alarm_active,
    output logic display_error,
    output logic display_blink,
    output logic [IO_W-1:0] io_display
);
    localparam int ERR_W = $clog2(ERR_CYCLES + 1);
    localparam int CLR_W = $clog2(CLEAR_CYCLES + 1);

    // The error display must outlast the eight-cycle hold check
    if (ERR_CYCLES < 8 || CLEAR_CYCLES < 1 || IO_W < 1 || IO_W > 32) begin : g_bad
        $error("odsm_top: unsupported parameter value");
    end

    function automatic logic signed [31:0] clamp(input logic signed [31:0] v);
        if (v > odsm_pkg::MON_LIMIT) begin
            clamp = odsm_pkg::MON_LIMIT;
        end else if (v < -odsm_pkg::MON_LIMIT) begin
            clamp = -odsm_pkg::MON_LIMIT;
        end else begin
            clamp = v;
        end
    endfunction

    logic [7:0] ctrl_reg;
    logic [15:0] gear_reg;
    logic [2:0] rd_idx_reg;
    logic [2:0] sel_meta_reg;
    logic [2:0] sel_sync_reg;
    logic [IO_W-1:0] io_meta_reg;
    logic [IO_W-1:0] io_sync_reg;
    logic [2:0] op_num_reg;
    logic [odsm_pkg::TRQ_W-1:0] trq_mem [0:odsm_pkg::SETS_FULL-1];
    logic [odsm_pkg::DAMP_W-1:0] damp_mem [0:odsm_pkg::SETS_FULL-1];
    logic [odsm_pkg::TRQ_W-1:0] act_trq_reg;
    logic [odsm_pkg::DAMP_W-1:0] act_damp_reg;
    logic [ERR_W-1:0] err_cnt_reg;
    logic [CLR_W-1:0] busy_cnt_reg;
    logic [odsm_pkg::BLINK_BITS-1:0] blink_cnt_reg;
    logic alm_act_reg;
    logic alm_nores_reg;
    logic [7:0] alm_code_reg;
    logic [3:0] alm_hist_reg;
    logic wrn_act_reg;
    logic [7:0] wrn_code_reg;
    logic [3:0] wrn_hist_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    // Decode
    wire setup_phase = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire wr_ctrl = apb_wr && (paddr == odsm_pkg::ADDR_CTRL);
    wire wr_data = apb_wr && (paddr == odsm_pkg::ADDR_DATA_WR);
    wire wr_idx = apb_wr && (paddr == odsm_pkg::ADDR_DATA_IDX);
    wire wr_gear = apb_wr && (paddr == odsm_pkg::ADDR_GEAR);
    wire odsm_pkg::odsm_mode_e mode = odsm_pkg::odsm_mode_e'(ctrl_reg[1:0]);
    wire mode_pos = (mode == odsm_pkg::ODSM_POSITION);
    wire mode_ten = (mode == odsm_pkg::ODSM_TENSION);
    wire edit_lock = ctrl_reg[odsm_pkg::CTRL_LOCK_BIT];

    // Commands are write-one pulses, never stored
    wire cmd_alm_rst = wr_ctrl && pwdata[odsm_pkg::CTRL_ALM_RST_BIT];
    wire cmd_alm_clr = wr_ctrl && pwdata[odsm_pkg::CTRL_ALM_CLR_BIT];
    wire cmd_wrn_clr = wr_ctrl && pwdata[odsm_pkg::CTRL_WRN_CLR_BIT];
    wire cmd_any = cmd_alm_rst || cmd_alm_clr || cmd_wrn_clr;

    // Entry check ahead of commit
    wire [2:0] entry_idx = pwdata[odsm_pkg::DWR_IDX_LSB +: 3];
    wire entry_damp = pwdata[odsm_pkg::DWR_ITEM_BIT];
    wire [15:0] entry_val = pwdata[15:0];
    wire trq_ok = entry_val <= odsm_pkg::TRQ_MAX; // RULE_06
    wire damp_ok = entry_val >= odsm_pkg::DAMP_MIN && entry_val <= odsm_pkg::DAMP_MAX; // RULE_07
    wire set_ok = !(mode_pos && entry_idx[2]); // RULE_01
    wire entry_ok = (entry_damp ? damp_ok : trq_ok) && set_ok; // RULE_22
    wire data_commit = wr_data && !edit_lock && entry_ok; // RULE_04
    wire data_reject = wr_data && !edit_lock && !entry_ok; // RULE_05
    wire err_active = (err_cnt_reg != '0);
    wire busy = (busy_cnt_reg != '0);

    // Active set number from the select inputs
    wire [2:0] sel_raw = {data_select_bit2, data_select_bit1, data_select_bit0};
    wire [2:0] sel_num = mode_pos ? {1'b0, sel_sync_reg[1:0]} : sel_sync_reg; // RULE_03

    // Monitors
    wire [15:0] gear_div = (ctrl_reg[odsm_pkg::CTRL_GEAR_BIT] && gear_reg != 16'h0000)
        ? gear_reg : 16'h0001;
    wire signed [31:0] speed_scaled = speed_rpm / $signed({16'h0000, gear_div}); // RULE_09
    wire signed [31:0] speed_clamped = clamp(speed_scaled); // RULE_21
    wire signed [31:0] speed_mon = (ctrl_reg[odsm_pkg::CTRL_ABS_BIT] && speed_clamped < 0)
        ? -speed_clamped : speed_clamped; // RULE_08
    wire signed [31:0] torque_mon = clamp(torque_pct); // RULE_10
    wire signed [31:0] inertia_mon = clamp(inertia_pct); // RULE_11
    wire signed [31:0] pos_mon = mode_pos ? clamp(cmd_position) : 32'h00000000; // RULE_13
    wire signed [31:0] ten_mon = mode_ten ? clamp(tension_cmd) : 32'h00000000; // RULE_14
    wire signed [31:0] revs_mon = mode_ten ? clamp(winding_revs) : 32'h00000000; // RULE_14
    wire signed [31:0] roll_mon = mode_ten ? clamp(roll_diameter) : 32'h00000000; // RULE_14
    wire signed [15:0] an_spd = analog_speed_mv / odsm_pkg::MV_PER_STEP; // RULE_20
    wire signed [15:0] an_trq = analog_torque_mv / odsm_pkg::MV_PER_STEP; // RULE_20
    wire [2:0] sel_report = mode_ten ? sel_sync_reg : 3'h0; // RULE_12
    wire [31:0] status_word = {19'h00000, wrn_act_reg, alm_nores_reg, alm_act_reg, busy,
        err_active, 1'b0, sel_report, 1'b0, op_num_reg};
    wire [31:0] alarm_word = {8'h00, wrn_hist_reg, alm_hist_reg, wrn_code_reg, alm_code_reg};
    wire [31:0] data_rd_word = {2'h0, damp_mem[rd_idx_reg], 7'h00, trq_mem[rd_idx_reg]};
    wire [31:0] io_word = 32'(io_sync_reg);

    // Read selection; unmapped offsets answer zero with an error
    wire hit_ctrl = paddr == odsm_pkg::ADDR_CTRL;
    wire hit_idx = paddr == odsm_pkg::ADDR_DATA_IDX;
    wire hit_drd = paddr == odsm_pkg::ADDR_DATA_RD;
    wire hit_dwr = paddr == odsm_pkg::ADDR_DATA_WR;
    wire [31:0] rd_mux =
        hit_ctrl ? {24'h000000, ctrl_reg} :
        hit_dwr ? 32'h00000000 :
        hit_idx ? {29'h00000000, rd_idx_reg} :
        hit_drd ? data_rd_word :
        (paddr == odsm_pkg::ADDR_STATUS) ? status_word :
        (paddr == odsm_pkg::ADDR_SPEED) ? speed_mon :
        (paddr == odsm_pkg::ADDR_TORQUE) ? torque_mon :
        (paddr == odsm_pkg::ADDR_INERTIA) ? inertia_mon :
        (paddr == odsm_pkg::ADDR_POSITION) ? pos_mon :
        (paddr == odsm_pkg::ADDR_TENSION) ? ten_mon :
        (paddr == odsm_pkg::ADDR_REVS) ? revs_mon :
        (paddr == odsm_pkg::ADDR_ROLL) ? roll_mon :
        (paddr == odsm_pkg::ADDR_IO) ? io_word :
        (paddr == odsm_pkg::ADDR_ANALOG) ? {an_trq, an_spd} :
        (paddr == odsm_pkg::ADDR_GEAR) ? {16'h0000, gear_reg} :
        (paddr == odsm_pkg::ADDR_ALARM) ? alarm_word : 32'h00000000;
    wire rd_hit = (paddr[1:0] == 2'h0) && (paddr <= odsm_pkg::ADDR_ALARM);

    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign op_number = op_num_reg;
    assign active_torque_limit = act_trq_reg;
    assign active_damping = act_damp_reg;
    assign alarm_active = alm_act_reg;
    assign display_error = err_active;
    assign display_blink = busy && blink_cnt_reg[odsm_pkg::BLINK_BITS-1]; // RULE_18
    assign io_display = io_sync_reg;

    // Read data is caught in the setup cycle so it leaves a flip-flop
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_reg <= !rd_hit;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= odsm_pkg::CTRL_RESET;
            gear_reg <= odsm_pkg::GEAR_RESET;
            rd_idx_reg <= 3'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= pwdata[7:0];
            end
            if (wr_gear) begin
                gear_reg <= pwdata[15:0];
            end
            if (wr_idx) begin
                rd_idx_reg <= pwdata[2:0];
            end
        end
    end

    // Two-stage sync on the pins; only the second stage is read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_meta_reg <= 3'h0;
            sel_sync_reg <= 3'h0;
            io_meta_reg <= '0;
            io_sync_reg <= '0;
        end else begin
            sel_meta_reg <= sel_raw;
            sel_sync_reg <= sel_meta_reg;
            io_meta_reg <= io_signals;
            io_sync_reg <= io_meta_reg; // RULE_19
        end
    end

    // Data sets live here, so removing the panel loses nothing
    generate
        for (genvar i = 0; i < odsm_pkg::SETS_FULL; i++) begin : g_set
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    trq_mem[i] <= odsm_pkg::TRQ_RESET; // RULE_06
                    damp_mem[i] <= odsm_pkg::DAMP_RESET; // RULE_07
                end else if (data_commit && entry_idx == 3'(i)) begin
                    if (entry_damp) begin
                        damp_mem[i] <= entry_val[odsm_pkg::DAMP_W-1:0]; // RULE_02
                    end else begin
                        trq_mem[i] <= entry_val[odsm_pkg::TRQ_W-1:0]; // RULE_02
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            op_num_reg <= 3'h0;
            act_trq_reg <= odsm_pkg::TRQ_RESET;
            act_damp_reg <= odsm_pkg::DAMP_RESET;
        end else begin
            op_num_reg <= sel_num; // RULE_03
            act_trq_reg <= trq_mem[op_num_reg];
            act_damp_reg <= damp_mem[op_num_reg];
        end
    end

    // Error and busy timers; a fresh reject restarts the full second
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            err_cnt_reg <= '0;
            busy_cnt_reg <= '0;
            blink_cnt_reg <= '0;
        end else begin
            if (data_reject) begin
                err_cnt_reg <= ERR_W'(ERR_CYCLES); // RULE_05
            end else if (err_active) begin
                err_cnt_reg <= err_cnt_reg - 1'b1;
            end
            if (cmd_any) begin
                busy_cnt_reg <= CLR_W'(CLEAR_CYCLES); // RULE_18
            end else if (busy) begin
                busy_cnt_reg <= busy_cnt_reg - 1'b1;
            end
            blink_cnt_reg <= busy ? blink_cnt_reg + 1'b1 : '0;
        end
    end

    // New events win over a clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            alm_act_reg <= 1'b0;
            alm_nores_reg <= 1'b0;
            alm_code_reg <= 8'h00;
            alm_hist_reg <= 4'h0;
            wrn_act_reg <= 1'b0;
            wrn_code_reg <= 8'h00;
            wrn_hist_reg <= 4'h0; // RULE_17
        end else begin
            if (alarm_event) begin
                alm_act_reg <= 1'b1; // RULE_15
                alm_nores_reg <= alarm_no_reset;
                alm_code_reg <= alarm_code;
            end else if (cmd_alm_rst && !alm_nores_reg) begin
                alm_act_reg <= 1'b0; // RULE_16
            end
            if (cmd_alm_clr) begin
                alm_hist_reg <= alarm_event ? 4'h1 : 4'h0;
            end else if (alarm_event && alm_hist_reg != odsm_pkg::HIST_MAX) begin
                alm_hist_reg <= alm_hist_reg + 1'b1;
            end
            if (warning_event) begin
                wrn_act_reg <= 1'b1; // RULE_15
                wrn_code_reg <= warning_code;
            end else if (cmd_wrn_clr) begin
                wrn_act_reg <= 1'b0;
            end
            if (cmd_wrn_clr) begin
                wrn_hist_reg <= warning_event ? 4'h1 : 4'h0;
            end else if (warning_event && wrn_hist_reg != odsm_pkg::HIST_MAX) begin
                wrn_hist_reg <= wrn_hist_reg + 1'b1;
            end
        end
    end

    property p_lock_refuse;
        @(posedge core_clk) disable iff (rst) wr_data && edit_lock && !entry_damp
            |=> trq_mem[$past(entry_idx)] == $past(trq_mem[entry_idx]);
    endproperty
    a_lock_refuse: assert property (p_lock_refuse) else $error("commit while locked"); // RULE_04

    property p_pos_sets;
        @(posedge core_clk) disable iff (rst) wr_data && mode_pos && entry_idx[2] && !entry_damp
            |=> trq_mem[$past(entry_idx)] == $past(trq_mem[entry_idx]);
    endproperty
    a_pos_sets: assert property (p_pos_sets) else $error("position set out of four"); // RULE_01

    property p_reject_keeps;
        @(posedge core_clk) disable iff (rst)
            data_reject && !entry_damp && set_ok |=> trq_mem[$past(entry_idx)] ==
            $past(trq_mem[entry_idx]) && err_active;
    endproperty
    a_reject_keeps: assert property (p_reject_keeps) else $error("reject altered data"); // RULE_22

    property p_trq_range;
        @(posedge core_clk) disable iff (rst)
            data_commit && !entry_damp |=> trq_mem[$past(entry_idx)] <= odsm_pkg::TRQ_MAX;
    endproperty
    a_trq_range: assert property (p_trq_range) else $error("torque limit over range"); // RULE_06

    property p_damp_range;
        @(posedge core_clk) disable iff (rst)
            data_commit && entry_damp |=> damp_mem[$past(entry_idx)] >= odsm_pkg::DAMP_MIN
            && damp_mem[$past(entry_idx)] <= odsm_pkg::DAMP_MAX;
    endproperty
    a_damp_range: assert property (p_damp_range) else $error("damping out of range"); // RULE_07

    property p_err_hold;
        @(posedge core_clk) disable iff (rst) data_reject |=> display_error [*8];
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error display too short"); // RULE_05

    property p_opnum;
        @(posedge core_clk) disable iff (rst)
            1'b1 |=> op_num_reg == ($past(mode_pos) ? {1'b0, $past(sel_sync_reg[1:0])}
            : $past(sel_sync_reg));
    endproperty
    a_opnum: assert property (p_opnum) else $error("wrong operation number"); // RULE_03

    property p_nonres;
        @(posedge core_clk) disable iff (rst)
            alm_act_reg && alm_nores_reg && cmd_alm_rst |=> alm_act_reg;
    endproperty
    a_nonres: assert property (p_nonres) else $error("locked alarm was reset"); // RULE_16

    property p_blink_idle;
        @(posedge core_clk) disable iff (rst) !busy |-> !display_blink;
    endproperty
    a_blink_idle: assert property (p_blink_idle) else $error("blink while idle"); // RULE_18

    property p_speed_limit;
        @(posedge core_clk) disable iff (rst)
            speed_mon <= odsm_pkg::MON_LIMIT && speed_mon >= -odsm_pkg::MON_LIMIT;
    endproperty
    a_speed_limit: assert property (p_speed_limit) else $error("speed past limit"); // RULE_21

    property p_sel_tension;
        @(posedge core_clk) disable iff (rst) !mode_ten |-> status_word[6:4] == 3'h0;
    endproperty
    a_sel_tension: assert property (p_sel_tension) else $error("selected number shown"); // RULE_12

    c_commit: cover property (@(posedge core_clk) disable iff (rst) data_commit);
    c_reject: cover property (@(posedge core_clk) disable iff (rst) data_reject);
    c_alarm_reset: cover property (@(posedge core_clk) disable iff (rst)
        alm_act_reg && cmd_alm_rst ##1 !alm_act_reg);
    c_blink: cover property (@(posedge core_clk) disable iff (rst) display_blink);
endmodule // odsm_top

// ===== tb.sv
`timescale 1ns/10ps
module tb;
    logic core_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, alarm_active, display_error, display_blink;
    logic [2:0] sel_req = 3'h0, op_number;
    logic alarm_req = 1'h0, hard_req = 1'h0, s0, s1, s2, a_ev, a_nr;
    logic [7:0] a_code;
    logic signed [31:0] speed_rpm = 0, torque_pct = 0, inertia_pct = 0, cmd_position = 0;
    logic signed [31:0] tension_cmd = 0, winding_revs = 0, roll_diameter = 0;
    logic warning_event = 1'h0;
    logic [7:0] warning_code = 8'h00;
    logic signed [15:0] analog_speed_mv = 16'sh0, analog_torque_mv = 16'sh0;
    logic [15:0] io_signals = 16'h0, io_display;
    logic [8:0] trq;
    logic [13:0] damp;
    int fails = 0, n_checks = 0;
    initial forever #50 core_clk = ~core_clk;
    odsm_ctrl_model PM (.core_clk, .sel_req, .alarm_req, .hard_req, .data_select_bit0(s0),
        .data_select_bit1(s1), .data_select_bit2(s2), .alarm_event(a_ev), .alarm_code(a_code),
        .alarm_no_reset(a_nr));
    // Error time shortened; busy time kept long enough for the blink to show
    odsm_top #(.ERR_CYCLES(20), .CLEAR_CYCLES(3000)) DUT (.core_clk, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .data_select_bit0(s0),
        .data_select_bit1(s1), .data_select_bit2(s2), .io_signals, .speed_rpm, .torque_pct,
        .inertia_pct, .cmd_position, .tension_cmd, .winding_revs,
        .roll_diameter, .analog_speed_mv, .analog_torque_mv, .alarm_event(a_ev),
        .alarm_code(a_code), .alarm_no_reset(a_nr), .warning_event,
        .warning_code, .op_number, .active_torque_limit(trq), .active_damping(damp),
        .alarm_active, .display_error, .display_blink, .io_display);
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        do @(posedge core_clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(n, rd, e);
    endtask
    task wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task t_data;
        rdchk("gear", 8'h38, 32'h1);
        apb(1'h1, 8'h04, 32'h0001_012C);
        apb(1'h1, 8'h08, 32'h1);
        rdchk("set1", 8'h0C, 32'h0BB8_012C);
        apb(1'h1, 8'h04, 32'h0001_012D);
        wt(1);
        chk("err", display_error, 32'h1);
        apb(1'h1, 8'h04, 32'h0011_02BB);
        apb(1'h1, 8'h04, 32'h0011_2710);
        rdchk("set1b", 8'h0C, 32'h2710_012C);
        wt(25);
        chk("err off", display_error, 32'h0);
        apb(1'h1, 8'h04, 32'h0004_0005);
        apb(1'h1, 8'h08, 32'h4);
        rdchk("set4", 8'h0C, 32'h0BB8_0000);
        apb(1'h1, 8'h00, 32'h4);
        apb(1'h1, 8'h04, 32'h0001_0007);
        apb(1'h1, 8'h00, 32'h0);
        apb(1'h1, 8'h08, 32'h1);
        rdchk("lock", 8'h0C, 32'h2710_012C);
    endtask
    task t_mon;
        speed_rpm <= -1500;
        torque_pct <= 100;
        inertia_pct <= 30000000;
        cmd_position <= -5;
        tension_cmd <= 77;
        winding_revs <= 1234;
        roll_diameter <= -30000000;
        analog_speed_mv <= 16'sh04D2;
        analog_torque_mv <= -16'sh00FA;
        io_signals <= 16'hA5C3;
        rdchk("pos", 8'h20, 32'hFFFF_FFFB);
        rdchk("ten0", 8'h24, 32'h0);
        rdchk("trq", 8'h18, 32'h64);
        rdchk("inr", 8'h1C, 32'h0131_2CFF);
        rdchk("spd", 8'h14, 32'hFFFF_FA24);
        apb(1'h1, 8'h00, 32'h8);
        rdchk("abs", 8'h14, 32'h5DC);
        apb(1'h1, 8'h38, 32'h2);
        apb(1'h1, 8'h00, 32'h18);
        rdchk("gear spd", 8'h14, 32'h2EE);
        rdchk("ana", 8'h34, 32'hFFFE_000C);
        chk("io", io_display, 32'hA5C3);
        rdchk("hole", 8'h40, 32'h0);
        chk("slverr", err, 32'h1);
    endtask
    task t_select;
        sel_req <= 3'h5;
        wt(8);
        chk("op pos", op_number, 32'h1);
        chk("act trq", trq, 32'h12C);
        chk("act damp", damp, 32'h2710);
        apb(1'h1, 8'h00, 32'h1);
        wt(8);
        chk("op spd", op_number, 32'h5);
        apb(1'h1, 8'h00, 32'h3);
        sel_req <= 3'h6;
        wt(8);
        apb(1'h0, 8'h10, 32'h0);
        chk("sel", rd[6:0], 32'h66);
        rdchk("ten", 8'h24, 32'h4D);
        rdchk("revs", 8'h28, 32'h4D2);
        rdchk("roll", 8'h2C, 32'hFECE_D301);
    endtask
    task t_alarm;
        alarm_req <= 1'h1;
        warning_event <= 1'h1;
        warning_code <= 8'h5C;
        wt(1);
        alarm_req <= 1'h0;
        warning_event <= 1'h0;
        wt(3);
        chk("alm", alarm_active, 32'h1);
        rdchk("code", 8'h3C, 32'h0011_5C2A);
        apb(1'h1, 8'h00, 32'h503);
        wt(2);
        chk("alm rst", alarm_active, 32'h0);
        rdchk("wrn clr", 8'h3C, 32'h0001_5C2A);
        hard_req <= 1'h1;
        alarm_req <= 1'h1;
        wt(1);
        alarm_req <= 1'h0;
        wt(3);
        apb(1'h1, 8'h00, 32'h103);
        wt(2);
        chk("alm hard", alarm_active, 32'h1);
        wt(2100);
        chk("blink", display_blink, 32'h1);
        wt(1000);
        chk("blink off", display_blink, 32'h0);
    endtask
    task stop_test;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'h0;
        t_data;
        t_mon;
        t_select;
        t_alarm;
        stop_test;
    end
    initial begin
        repeat (10000) @(posedge core_clk);
        fails++;
        stop_test;
    end
endmodule // tb
